// file: hdl/ssc_pkg.sv
package ssc_pkg;

  // configuration register indices
  localparam logic [7:0] IDX_SHD_L2CTL = 8'h18;
  localparam logic [7:0] IDX_SHD_RD    = 8'h19;
  localparam logic [7:0] IDX_SHD_WR    = 8'h1A;
  localparam logic [7:0] IDX_SMM_SHD   = 8'h1C;
  localparam logic [7:0] IDX_SMM_MISC  = 8'h94;

  // values after reset
  localparam logic [7:0] RST_REG       = 8'h00;
  localparam logic [7:0] RST_RDATA     = 8'h00;
  localparam logic [2:0] RST_CNT       = 3'h0;

  // field positions
  localparam int BIT_L2_SHD_OFF   = 3;
  localparam int BIT_L1_SHD_OFF   = 2;
  localparam int BIT_SMM_L1_OFF   = 3;
  localparam int BIT_A20_FORCE    = 2;
  localparam int BIT_STROBE_CPU   = 1;
  localparam int BIT_FLUSH_EN     = 0;
  localparam int BIT_STS_SMM      = 7;
  localparam int BIT_STS_FLUSH    = 6;
  localparam logic [7:0] MISC_WMASK = 8'h0F;
  localparam logic [2:0] SMM_RD_LSB = 3'h0;
  localparam logic [2:0] SMM_WR_LSB = 3'h4;
  localparam logic [2:0] USR_DEF_LSB = 3'h4;

  // 64K segments inside the low megabyte
  localparam logic [3:0] SEG_C = 4'hC;
  localparam logic [3:0] SEG_D = 4'hD;
  localparam logic [11:0] LOW_MEG = 12'h000;

  // flush pulse length in clocks
  localparam logic [2:0] FLUSH_CYC = 3'h4;

  // gate codes on the inter-chip link, values arbitrary
  localparam logic [7:0] A20_SET_CODE = 8'h01;
  localparam logic [7:0] A20_CLR_CODE = 8'h02;

  typedef enum logic [1:0]
  {
    LK_IDLE = 2'b00,
    LK_SEND = 2'b01,
    LK_DONE = 2'b11
  } ssc_link_st_t;

  typedef enum logic
  {
    FL_IDLE  = 1'b0,
    FL_DRIVE = 1'b1
  } ssc_flush_st_t;

endpackage

// file: hdl/ssc_a20_link.sv
`timescale 1ns/10ps
module ssc_a20_link #(
  parameter int CODE_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              send_req,
  input  wire logic [CODE_W-1:0] send_code,
  input  wire logic              link_ack,
  output logic                   link_valid_r,
  output logic [CODE_W-1:0]      link_code_r
);

  ssc_pkg::ssc_link_st_t st_r;
  ssc_pkg::ssc_link_st_t st_nxt;
  logic                  pend_v_r;
  logic                  pend_v_nxt;
  logic [CODE_W-1:0]     pend_r;
  logic [CODE_W-1:0]     pend_nxt;
  logic                  link_valid_nxt;
  logic [CODE_W-1:0]     link_code_nxt;

  // four-phase handshake; a newer code overwrites one still waiting
  always_comb
  begin
    st_nxt         = st_r;
    pend_v_nxt     = pend_v_r;
    pend_nxt       = pend_r;
    link_valid_nxt = link_valid_r;
    link_code_nxt  = link_code_r;
    if (send_req)
    begin
      pend_v_nxt = 1'b1;
      pend_nxt   = send_code;
    end
    unique case (st_r)
      ssc_pkg::LK_IDLE:
      begin
        if (pend_v_r && !send_req)
        begin
          st_nxt         = ssc_pkg::LK_SEND;
          link_valid_nxt = 1'b1;
          link_code_nxt  = pend_r;
          pend_v_nxt     = 1'b0;
        end
      end
      ssc_pkg::LK_SEND:
      begin
        if (link_ack)
        begin
          st_nxt         = ssc_pkg::LK_DONE;
          link_valid_nxt = 1'b0;
        end
      end
      ssc_pkg::LK_DONE:
      begin
        if (!link_ack)
        begin
          st_nxt = ssc_pkg::LK_IDLE;
        end
      end
      default:
      begin
        st_nxt         = ssc_pkg::LK_IDLE;
        link_valid_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_r         <= ssc_pkg::LK_IDLE;
      pend_v_r     <= 1'b0;
      pend_r       <= '0;
      link_valid_r <= 1'b0;
      link_code_r  <= '0;
    end
    else
    begin
      st_r         <= st_nxt;
      pend_v_r     <= pend_v_nxt;
      pend_r       <= pend_nxt;
      link_valid_r <= link_valid_nxt;
      link_code_r  <= link_code_nxt;
    end
  end

endmodule // ssc_a20_link

// file: hdl/ssc_smm_shadow.sv
// Contract
// - smm memory only in D0000-FFFFF shadow
// - pick user or smm enables per cycle
// - D, E, F each own smm control
// - smm enable bit mapping; C uses user bits
// - cleared smm enable sends range to isa
// - user and smm share same shadow dram
// - flush low four clocks on smm entry
// - no entry flush for strobe-type cpu
// - no flush on exit, none for l2
// - index 94h bit 3 sets smm l1 caching
// - index 18h bit 3 sets shadow l2 caching
// - a20 gate ors inverted smm active level
// - set code on entry, reset on exit
// - no codes if gate already high
// - no a20 forcing for strobe-type cpu
`timescale 1ns/10ps
module ssc_smm_shadow #(
  parameter int CODE_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              cpu_ads_n,
  input  wire logic              smm_cycle_strobe_n,
  input  wire logic              smm_active_n,
  input  wire logic              cpu_wr,
  input  wire logic [31:14]      cpu_addr,
  input  wire logic              kbd_gate,
  input  wire logic              emu_gate,
  input  wire logic              link_ack,
  input  wire logic              cfg_wr,
  input  wire logic              cfg_rd,
  input  wire logic [7:0]        cfg_index,
  input  wire logic [7:0]        cfg_wdata,
  output logic [7:0]             cfg_rdata_r,
  output logic                   shd_sel_r,
  output logic                   shd_dram_r,
  output logic                   shd_isa_r,
  output logic                   shd_smm_r,
  output logic                   shd_l1_cache_r,
  output logic                   shd_l2_cache_r,
  output logic                   cpu_flush_n_r,
  output logic                   addr20_gate_r,
  output logic                   link_valid_r,
  output logic [CODE_W-1:0]      link_code_r
);

  localparam int PIN_W = 23;

  // pin synchronisers
  logic [PIN_W-1:0]          pin_s1_r;
  logic [PIN_W-1:0]          pin_s2_r;
  logic                      ads_n_s;
  logic                      strobe_n_s;
  logic                      active_n_s;
  logic                      wr_s;
  logic                      ack_s;
  logic [31:14]              addr_s;

  // configuration registers
  logic [7:0]                l2ctl_r;
  logic [7:0]                l2ctl_nxt;
  logic [7:0]                shd_rd_r;
  logic [7:0]                shd_rd_nxt;
  logic [7:0]                shd_wr_r;
  logic [7:0]                shd_wr_nxt;
  logic [7:0]                smm_ctl_r;
  logic [7:0]                smm_ctl_nxt;
  logic [7:0]                misc_r;
  logic [7:0]                misc_nxt;
  logic [7:0]                cfg_rdata_nxt;

  // cycle decode
  logic                      strobe_cpu;
  logic                      cyc_start;
  logic                      smm_q;
  logic                      in_low;
  logic [3:0]                seg;
  logic [1:0]                quad;
  logic [7:0]                usr_en;
  logic [2:0]                rng;
  logic                      en;
  logic                      sel;
  logic                      shd_sel_nxt;
  logic                      shd_dram_nxt;
  logic                      shd_isa_nxt;
  logic                      shd_smm_nxt;
  logic                      shd_l1_nxt;
  logic                      shd_l2_nxt;

  // smm entry and exit
  logic                      act_prev_r;
  logic                      smm_entry;
  logic                      smm_exit;
  ssc_pkg::ssc_flush_st_t    fl_st_r;
  ssc_pkg::ssc_flush_st_t    fl_st_nxt;
  logic [2:0]                fl_cnt_r;
  logic [2:0]                fl_cnt_nxt;
  logic                      cpu_flush_n_nxt;
  logic                      force_on;
  logic                      gate_base;
  logic                      addr20_gate_nxt;
  logic                      send_req;
  logic [CODE_W-1:0]         send_code;

  // two flops on every cpu bus pin and on link_ack before use
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pin_s1_r <= {5'h1F, 18'h00000};
      pin_s2_r <= {5'h1F, 18'h00000};
    end
    else
    begin
      pin_s1_r <= {cpu_ads_n, smm_cycle_strobe_n, smm_active_n, cpu_wr, link_ack, cpu_addr};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign ads_n_s    = pin_s2_r[22];
  assign strobe_n_s = pin_s2_r[21];
  assign active_n_s = pin_s2_r[20];
  assign wr_s       = pin_s2_r[19];
  assign ack_s      = pin_s2_r[18];
  assign addr_s     = pin_s2_r[17:0];

  // configuration writes and reads
  always_comb
  begin
    l2ctl_nxt     = l2ctl_r;
    shd_rd_nxt    = shd_rd_r;
    shd_wr_nxt    = shd_wr_r;
    smm_ctl_nxt   = smm_ctl_r;
    misc_nxt      = misc_r;
    cfg_rdata_nxt = cfg_rdata_r;
    if (cfg_wr)
    begin
      unique case (cfg_index)
        ssc_pkg::IDX_SHD_L2CTL: l2ctl_nxt   = cfg_wdata;
        ssc_pkg::IDX_SHD_RD:    shd_rd_nxt  = cfg_wdata;
        ssc_pkg::IDX_SHD_WR:    shd_wr_nxt  = cfg_wdata;
        ssc_pkg::IDX_SMM_SHD:   smm_ctl_nxt = cfg_wdata;
        ssc_pkg::IDX_SMM_MISC:  misc_nxt    = cfg_wdata & ssc_pkg::MISC_WMASK;
        default:                misc_nxt    = misc_r;
      endcase
    end
    if (cfg_rd)
    begin
      unique case (cfg_index)
        ssc_pkg::IDX_SHD_L2CTL: cfg_rdata_nxt = l2ctl_r;
        ssc_pkg::IDX_SHD_RD:    cfg_rdata_nxt = shd_rd_r;
        ssc_pkg::IDX_SHD_WR:    cfg_rdata_nxt = shd_wr_r;
        ssc_pkg::IDX_SMM_SHD:   cfg_rdata_nxt = smm_ctl_r;
        ssc_pkg::IDX_SMM_MISC:
        begin
          cfg_rdata_nxt                         = misc_r;
          cfg_rdata_nxt[ssc_pkg::BIT_STS_SMM]   = ~strobe_cpu & ~active_n_s;
          cfg_rdata_nxt[ssc_pkg::BIT_STS_FLUSH] = ~cpu_flush_n_r;
        end
        default:                cfg_rdata_nxt = ssc_pkg::RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      l2ctl_r     <= ssc_pkg::RST_REG;
      shd_rd_r    <= ssc_pkg::RST_REG;
      shd_wr_r    <= ssc_pkg::RST_REG;
      smm_ctl_r   <= ssc_pkg::RST_REG;
      misc_r      <= ssc_pkg::RST_REG;
      cfg_rdata_r <= ssc_pkg::RST_RDATA;
    end
    else
    begin
      l2ctl_r     <= l2ctl_nxt;
      shd_rd_r    <= shd_rd_nxt;
      shd_wr_r    <= shd_wr_nxt;
      smm_ctl_r   <= smm_ctl_nxt;
      misc_r      <= misc_nxt;
      cfg_rdata_r <= cfg_rdata_nxt;
    end
  end

  // qualifier source depends on how the cpu signals smm
  assign strobe_cpu = misc_r[ssc_pkg::BIT_STROBE_CPU];
  always_comb
  begin
    cyc_start = strobe_cpu ? (~ads_n_s | ~strobe_n_s) : ~ads_n_s;
    smm_q     = strobe_cpu ? ~strobe_n_s : ~active_n_s;
  end

  // shadow decode of the C0000-FFFFF window
  always_comb
  begin
    in_low = (addr_s[31:20] == ssc_pkg::LOW_MEG);
    seg    = addr_s[19:16];
    quad   = addr_s[15:14];
    usr_en = wr_s ? shd_wr_r : shd_rd_r;
    rng    = 3'(seg - ssc_pkg::SEG_D);
    sel    = in_low && (seg >= ssc_pkg::SEG_C);
    en     = 1'b0;
    if (sel && seg == ssc_pkg::SEG_C)
    begin
      en = usr_en[quad];
    end
    else if (sel && smm_q)
    begin
      // separate smm enables only for D, E and F
      en = smm_ctl_r[(wr_s ? ssc_pkg::SMM_WR_LSB : ssc_pkg::SMM_RD_LSB) + rng];
    end
    else if (sel)
    begin
      en = usr_en[ssc_pkg::USR_DEF_LSB + rng];
    end
    shd_sel_nxt  = shd_sel_r;
    shd_dram_nxt = shd_dram_r;
    shd_isa_nxt  = shd_isa_r;
    shd_smm_nxt  = shd_smm_r;
    shd_l1_nxt   = shd_l1_cache_r;
    shd_l2_nxt   = shd_l2_cache_r;
    if (cyc_start)
    begin
      // latched once per cycle, held until the next start
      shd_sel_nxt  = sel;
      shd_smm_nxt  = smm_q;
      shd_dram_nxt = sel & en;
      shd_isa_nxt  = sel & ~en;
      shd_l1_nxt   = sel & en & ~l2ctl_r[ssc_pkg::BIT_L1_SHD_OFF]
                     & ~(smm_q & misc_r[ssc_pkg::BIT_SMM_L1_OFF]);
      shd_l2_nxt   = sel & en & ~l2ctl_r[ssc_pkg::BIT_L2_SHD_OFF];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      shd_sel_r      <= 1'b0;
      shd_dram_r     <= 1'b0;
      shd_isa_r      <= 1'b0;
      shd_smm_r      <= 1'b0;
      shd_l1_cache_r <= 1'b0;
      shd_l2_cache_r <= 1'b0;
    end
    else
    begin
      shd_sel_r      <= shd_sel_nxt;
      shd_dram_r     <= shd_dram_nxt;
      shd_isa_r      <= shd_isa_nxt;
      shd_smm_r      <= shd_smm_nxt;
      shd_l1_cache_r <= shd_l1_nxt;
      shd_l2_cache_r <= shd_l2_nxt;
    end
  end

  // entry and exit edges of the static active level
  always_comb
  begin
    smm_entry = ~strobe_cpu & act_prev_r & ~active_n_s;
    smm_exit  = ~strobe_cpu & ~act_prev_r & active_n_s;
  end

  // flush pulse on entry only, never on exit
  always_comb
  begin
    fl_st_nxt  = fl_st_r;
    fl_cnt_nxt = fl_cnt_r;
    unique case (fl_st_r)
      ssc_pkg::FL_IDLE:
      begin
        if (smm_entry && misc_r[ssc_pkg::BIT_FLUSH_EN])
        begin
          fl_st_nxt  = ssc_pkg::FL_DRIVE;
          fl_cnt_nxt = 3'(ssc_pkg::FLUSH_CYC - 3'h1);
        end
      end
      ssc_pkg::FL_DRIVE:
      begin
        if (fl_cnt_r == ssc_pkg::RST_CNT)
        begin
          fl_st_nxt = ssc_pkg::FL_IDLE;
        end
        else
        begin
          fl_cnt_nxt = 3'(fl_cnt_r - 3'h1);
        end
      end
    endcase
    cpu_flush_n_nxt = (fl_st_nxt != ssc_pkg::FL_DRIVE);
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      act_prev_r    <= 1'b1;
      fl_st_r       <= ssc_pkg::FL_IDLE;
      fl_cnt_r      <= ssc_pkg::RST_CNT;
      cpu_flush_n_r <= 1'b1;
    end
    else
    begin
      act_prev_r    <= active_n_s;
      fl_st_r       <= fl_st_nxt;
      fl_cnt_r      <= fl_cnt_nxt;
      cpu_flush_n_r <= cpu_flush_n_nxt;
    end
  end

  // internal a20 gate and link codes
  always_comb
  begin
    force_on        = misc_r[ssc_pkg::BIT_A20_FORCE] & ~strobe_cpu & ~active_n_s;
    gate_base       = kbd_gate | emu_gate;
    addr20_gate_nxt = gate_base | force_on;
    send_req        = 1'b0;
    send_code       = ssc_pkg::A20_SET_CODE;
    if (misc_r[ssc_pkg::BIT_A20_FORCE] && !gate_base)
    begin
      if (smm_entry)
      begin
        send_req  = 1'b1;
        send_code = ssc_pkg::A20_SET_CODE;
      end
      else if (smm_exit)
      begin
        send_req  = 1'b1;
        send_code = ssc_pkg::A20_CLR_CODE;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      addr20_gate_r <= 1'b0;
    end
    else
    begin
      addr20_gate_r <= addr20_gate_nxt;
    end
  end

  ssc_a20_link #(
    .CODE_W (CODE_W)
  ) u_link (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .send_req     (send_req),
    .send_code    (send_code),
    .link_ack     (ack_s),
    .link_valid_r (link_valid_r),
    .link_code_r  (link_code_r)
  );

endmodule // ssc_smm_shadow

// file: bench/ssc_smm_shadow_monitor.sv
`timescale 1ns/10ps
module ssc_smm_shadow_monitor (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       cpu_ads_n,
  input wire logic       smm_cycle_strobe_n,
  input wire logic       smm_active_n,
  input wire logic       kbd_gate,
  input wire logic       emu_gate,
  input wire logic       link_ack,
  input wire logic       cfg_wr,
  input wire logic       cfg_rd,
  input wire logic [7:0] cfg_index,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata_r,
  input wire logic       shd_sel_r,
  input wire logic       shd_dram_r,
  input wire logic       shd_isa_r,
  input wire logic       shd_smm_r,
  input wire logic       cpu_flush_n_r,
  input wire logic       addr20_gate_r,
  input wire logic       link_valid_r,
  input wire logic [7:0] link_code_r
);
  logic [3:0] misc_r, misc_nxt, ent_r, ent_nxt, st_r, st_nxt;
  logic       smm_q_r, smm_q_nxt;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // shadow of the mode bits, entry and cycle-start history
  always_comb
  begin
    misc_nxt = misc_r;
    if (cfg_wr && cfg_index == ssc_pkg::IDX_SMM_MISC)
      misc_nxt = cfg_wdata[3:0];
    smm_q_nxt = smm_active_n;
    ent_nxt = {ent_r[2:0], misc_r[0] & ~misc_r[1] & smm_q_r & ~smm_active_n};
    st_nxt = {st_r[2:0], ~cpu_ads_n | ~smm_cycle_strobe_n};
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      misc_r  <= 4'h0;
      ent_r   <= 4'h0;
      st_r    <= 4'h0;
      smm_q_r <= 1'h1;
    end
    else
    begin
      misc_r  <= misc_nxt;
      ent_r   <= ent_nxt;
      st_r    <= st_nxt;
      smm_q_r <= smm_q_nxt;
    end
  end

  sel_split_a: assert property (
    shd_sel_r == (shd_dram_r | shd_isa_r) && !(shd_dram_r && shd_isa_r))
    else $error("decode select not split into dram or isa");
  decode_hold_a: assert property (
    $changed({shd_sel_r, shd_dram_r}) |-> st_r != 4'h0)
    else $error("decode changed without a cycle start");
  flush_len_a: assert property (
    $fell(cpu_flush_n_r) |-> !cpu_flush_n_r [*4] ##1 cpu_flush_n_r)
    else $error("flush pulse not four clocks");
  flush_cause_a: assert property (
    $fell(cpu_flush_n_r) |-> ent_r != 4'h0)
    else $error("flush without enabled static entry");
  gate_or_a: assert property (
    $past(kbd_gate | emu_gate) |-> addr20_gate_r)
    else $error("gate misses keyboard sources");
  gate_only_a: assert property (
    (misc_r[1] | ~misc_r[2]) && $past(misc_r[1] | ~misc_r[2])
      |-> addr20_gate_r == $past(kbd_gate | emu_gate))
    else $error("gate forced while forcing off");
  link_cause_a: assert property (
    $rose(link_valid_r) |-> misc_r[2] && !misc_r[1])
    else $error("gate code sent while forcing off");
  link_gate_a: assert property (
    $rose(link_valid_r) |-> !$past(kbd_gate | emu_gate, 2))
    else $error("gate code sent with gate already high");
  link_hold_a: assert property (
    link_valid_r && !link_ack |=> link_valid_r && $stable(link_code_r))
    else $error("link code dropped before ack");

  cover property ($fell(cpu_flush_n_r));
  cover property ($rose(link_valid_r));
  cover property (shd_smm_r && shd_dram_r);
endmodule // ssc_smm_shadow_monitor

// file: bench/ssc_cpu_model.sv
`timescale 1ns/10ps
module ssc_cpu_model #(
  parameter int ACK_DLY = 2
) (
  input  wire logic   core_clk,
  input  wire logic   link_valid_r,
  output logic        cpu_ads_n,
  output logic        smm_cycle_strobe_n,
  output logic        smm_active_n,
  output logic        cpu_wr,
  output logic [31:14] cpu_addr,
  output logic        link_ack
);
  int cnt;

  initial
  begin
    {cpu_ads_n, smm_cycle_strobe_n, smm_active_n, cpu_wr} = 4'hE;
    cpu_addr = 18'h3FFFF;
    link_ack = 1'h0;
    cnt = 0;
  end

  // level stays put across every cycle of the smm session
  task automatic set_smm(input logic lvl);
    @(posedge core_clk);
    #1 smm_active_n = lvl;
  endtask

  // one-clock start, bus lines inverted once released
  task automatic cycle(input logic [31:0] a, input logic w, input logic stb);
    @(posedge core_clk);
    #1 cpu_addr = a[31:14];
    cpu_wr = w;
    cpu_ads_n = stb;
    smm_cycle_strobe_n = ~stb;
    @(posedge core_clk);
    #1 cpu_ads_n = 1'h1;
    smm_cycle_strobe_n = 1'h1;
    cpu_addr = ~a[31:14];
    cpu_wr = ~w;
  endtask

  // companion answers each code four-phase after a delay
  always @(posedge core_clk)
  begin
    cnt <= (link_valid_r && !link_ack) ? cnt + 1 : 0;
    if (cnt == ACK_DLY)
      link_ack <= 1'h1;
    else if (!link_valid_r)
      link_ack <= 1'h0;
  end
endmodule // ssc_cpu_model

// file: bench/ssc_smm_shadow_bench.sv
`timescale 1ns/10ps
module ssc_smm_shadow_bench;
  localparam logic [7:0] U_RD = 8'h35;
  localparam logic [7:0] U_WR = 8'h4A;
  localparam logic [7:0] S_CTL = 8'h62;
  logic         core_clk, sys_rst, kbd_gate, emu_gate, cfg_wr, cfg_rd;
  logic         cpu_ads_n, smm_cycle_strobe_n, smm_active_n, cpu_wr, link_ack;
  logic         cpu_flush_n_r, addr20_gate_r, link_valid_r;
  logic [7:0]   cfg_index, cfg_wdata, cfg_rdata_r, link_code_r, c18, c94;
  logic [31:14] cpu_addr;
  logic [5:0]   dec;
  logic [31:0]  adr [8];
  int           n_errors, tests_run;
  int           cyc = 0;

  ssc_smm_shadow i_ssc_smm_shadow (.core_clk, .sys_rst, .cpu_ads_n, .smm_cycle_strobe_n,
    .smm_active_n, .cpu_wr, .cpu_addr, .kbd_gate, .emu_gate, .link_ack, .cfg_wr, .cfg_rd,
    .cfg_index, .cfg_wdata, .cfg_rdata_r, .shd_sel_r(dec[5]), .shd_dram_r(dec[4]),
    .shd_isa_r(dec[3]), .shd_smm_r(dec[2]), .shd_l1_cache_r(dec[1]),
    .shd_l2_cache_r(dec[0]), .cpu_flush_n_r, .addr20_gate_r, .link_valid_r, .link_code_r);
  ssc_cpu_model i_ssc_cpu_model (.core_clk, .link_valid_r, .cpu_ads_n, .smm_cycle_strobe_n,
    .smm_active_n, .cpu_wr, .cpu_addr, .link_ack);

  initial
  begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [5:0] exp_dec(input logic [31:0] a, input logic w, input logic s);
    logic [1:0] k;
    logic       en;
    k = a[17:16] - 2'h1;
    if (a[19:16] == 4'hC)
      en = w ? U_WR[a[15:14]] : U_RD[a[15:14]];
    else
      en = s ? S_CTL[{w, k}] : (w ? U_WR[{1'h1, k}] : U_RD[{1'h1, k}]);
    if (a[31:20] != 12'h000 || a[19:18] != 2'h3)
      return {3'h0, s, 2'h0};
    return {1'h1, en, ~en, s, en & ~c18[2] & ~(s & c94[3]), en & ~c18[3]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(posedge core_clk);
    #1 cfg_wr = 1'h1;
    cfg_index = i;
    cfg_wdata = d;
    @(posedge core_clk);
    #1 cfg_wr = 1'h0;
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    @(posedge core_clk);
    #1 cfg_rd = 1'h1;
    cfg_index = i;
    @(posedge core_clk);
    #1 cfg_rd = 1'h0;
    @(posedge core_clk);
    #1 chk(cfg_rdata_r, e);
  endtask

  task automatic bus(input logic [31:0] a, input logic w, input logic stb, input logic s);
    i_ssc_cpu_model.cycle(a, w, stb);
    repeat (3) @(posedge core_clk);
    #1 chk({2'h0, dec}, {2'h0, exp_dec(a, w, s)});
  endtask

  task automatic watch(input logic [7:0] ef, input logic [7:0] ev);
    logic [7:0] nf, nv;
    nf = 8'h00;
    nv = 8'h00;
    repeat (12)
    begin
      @(posedge core_clk);
      #1 nf = nf + {7'h00, cpu_flush_n_r === 1'h0};
      nv = nv + {7'h00, link_valid_r === 1'h1};
    end
    chk(nf, ef);
    chk(nv, ev);
  endtask

  task automatic wait_code(input logic [7:0] e);
    int t;
    t = 0;
    while (link_valid_r !== 1'h1 && t < 30)
    begin
      @(posedge core_clk);
      #1 t++;
    end
    chk({7'h00, link_valid_r}, 8'h01);
    chk(link_code_r, e);
    chk({7'h00, addr20_gate_r}, {7'h00, e == ssc_pkg::A20_SET_CODE});
    while (link_valid_r !== 1'h0 && t < 60)
    begin
      @(posedge core_clk);
      #1 t++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  initial
  begin
    adr = '{32'hC4000, 32'hCC000, 32'hD0000, 32'hE8000, 32'hF0000, 32'hA0000, 32'h1D0000,
      32'h38000};
    {sys_rst, kbd_gate, emu_gate, cfg_wr, cfg_rd} = 5'h10;
    cfg_index = 8'h00;
    cfg_wdata = 8'h00;
    n_errors = 0;
    tests_run = 0;
    repeat (5) @(posedge core_clk);
    #1 sys_rst = 1'h0;
    rd(ssc_pkg::IDX_SHD_L2CTL, 8'h00);
    rd(ssc_pkg::IDX_SHD_RD, 8'h00);
    rd(ssc_pkg::IDX_SMM_SHD, 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    wr(ssc_pkg::IDX_SMM_MISC, 8'hFF);
    rd(ssc_pkg::IDX_SMM_MISC, 8'h0F);
    wr(ssc_pkg::IDX_SHD_RD, U_RD);
    wr(ssc_pkg::IDX_SHD_WR, U_WR);
    wr(ssc_pkg::IDX_SMM_SHD, S_CTL);
    rd(ssc_pkg::IDX_SHD_WR, U_WR);
    // user and smm views, cached and uncached
    for (int c = 0; c < 2; c++)
    begin
      c18 = c ? 8'h08 : 8'h04;
      c94 = c18 & 8'h08;
      wr(ssc_pkg::IDX_SHD_L2CTL, c18);
      wr(ssc_pkg::IDX_SMM_MISC, c94);
      for (int s = 0; s < 2; s++)
      begin
        i_ssc_cpu_model.set_smm(s == 0);
        repeat (4) @(posedge core_clk);
        foreach (adr[i])
          for (int w = 0; w < 2; w++)
            bus(adr[i], w[0], 1'h0, s[0]);
      end
    end
    // strobe-type cpu: level ignored, no flush, no forcing
    c94 = 8'h07;
    wr(ssc_pkg::IDX_SMM_MISC, c94);
    watch(8'h00, 8'h00);
    chk({7'h00, addr20_gate_r}, 8'h00);
    bus(32'hD0000, 1'h0, 1'h1, 1'h1);
    bus(32'hD0000, 1'h0, 1'h0, 1'h0);
    i_ssc_cpu_model.set_smm(1'h1);
    // entry flush
    wr(ssc_pkg::IDX_SMM_MISC, 8'h01);
    i_ssc_cpu_model.set_smm(1'h0);
    watch(8'h04, 8'h00);
    i_ssc_cpu_model.set_smm(1'h1);
    watch(8'h00, 8'h00);
    // forced gate and link codes
    wr(ssc_pkg::IDX_SMM_MISC, 8'h04);
    i_ssc_cpu_model.set_smm(1'h0);
    wait_code(ssc_pkg::A20_SET_CODE);
    rd(ssc_pkg::IDX_SMM_MISC, 8'h84);
    i_ssc_cpu_model.set_smm(1'h1);
    wait_code(ssc_pkg::A20_CLR_CODE);
    @(posedge core_clk);
    #1 emu_gate = 1'h1;
    i_ssc_cpu_model.set_smm(1'h0);
    watch(8'h00, 8'h00);
    chk({7'h00, addr20_gate_r}, 8'h01);
    i_ssc_cpu_model.set_smm(1'h1);
    watch(8'h00, 8'h00);
    @(posedge core_clk);
    #1 emu_gate = 1'h0;
    kbd_gate = 1'h1;
    @(posedge core_clk);
    #1 chk({7'h00, addr20_gate_r}, 8'h01);
    kbd_gate = 1'h0;
    wrap_up();
  end
endmodule // ssc_smm_shadow_bench

bind ssc_smm_shadow ssc_smm_shadow_monitor i_ssc_smm_shadow_monitor (.core_clk, .sys_rst,
  .cpu_ads_n, .smm_cycle_strobe_n, .smm_active_n, .kbd_gate, .emu_gate, .link_ack, .cfg_wr,
  .cfg_rd, .cfg_index, .cfg_wdata, .cfg_rdata_r, .shd_sel_r, .shd_dram_r, .shd_isa_r,
  .shd_smm_r, .cpu_flush_n_r, .addr20_gate_r, .link_valid_r, .link_code_r);
